// >>> ubfw_cfg.svh
// Purpose: constants of the serial channel core
// Assumes: 32-bit register bus, byte addresses
// Notes:   definitions only
`ifndef UBFW_CFG_SVH
`define UBFW_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define UBFW_OFF_DATA      8'h00
`define UBFW_OFF_BAUD      8'h04
`define UBFW_OFF_TOR       8'h08
`define UBFW_OFF_ISR       8'h0C
`define UBFW_OFF_LSR       8'h10
`define UBFW_OFF_FUNSEL    8'h14
`define UBFW_OFF_CTRL      8'h18

// ****************************************************************
// field positions
// ****************************************************************
`define UBFW_BAUD_DIV      15:0
`define UBFW_BAUD_PRE      27:24
`define UBFW_BAUD_MODE     29:28
`define UBFW_TOR_GAP       15:8
`define UBFW_ISR_BUFERR    5
`define UBFW_ISR_TXOVER    8
`define UBFW_ISR_RXOVER    9
`define UBFW_ISR_WAKE      10
`define UBFW_CTRL_PAREN    0
`define UBFW_CTRL_WAKEEN   1

// ****************************************************************
// mode codes, reset values and counts
// ****************************************************************
`define UBFW_MODE_0        2'h0
`define UBFW_MODE_1        2'h2
`define UBFW_MODE_2        2'h3
`define UBFW_RST_BAUD      32'h0000_0000
`define UBFW_RST_TOR       32'h0000_0000
`define UBFW_FIFO_DEPTH    16
`define UBFW_MODE0_MUL     24'h10
`define UBFW_BAUD_OFS      24'h2
`define UBFW_PRE_MIN       4'h8
`define UBFW_M2_DIV_MIN    16'h9

`endif

// >>> ubfw_pkg.sv
// Purpose: types of the serial channel core
// Assumes: constants come from ubfw_cfg.svh
// Notes:   one-hot state codes
`default_nettype none
package ubfw_pkg;

    typedef enum logic [5:0] {
        TX_IDLE  = 6'h01,
        TX_START = 6'h02,
        TX_DATA  = 6'h04,
        TX_PAR   = 6'h08,
        TX_STOP  = 6'h10,
        TX_GAP   = 6'h20
    } ubfw_tx_e;

    typedef enum logic [4:0] {
        RX_IDLE  = 5'h01,
        RX_START = 5'h02,
        RX_DATA  = 5'h04,
        RX_PAR   = 5'h08,
        RX_STOP  = 5'h10
    } ubfw_rx_e;

    typedef enum logic [1:0] {
        FN_UART  = 2'h0,
        FN_LIN   = 2'h1,
        FN_IRDA  = 2'h2,
        FN_RS485 = 2'h3
    } ubfw_fn_e;

endpackage
`default_nettype wire

// >>> ubfw_fifo.sv
// Purpose: synchronous queue with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   read data is the head entry, shown while out_valid_out
`timescale 1ns/1ps
`default_nettype none
module ubfw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic                       mclk_in,
    input  wire logic                       rst_n_in,
    // fill side
    input  wire logic                       in_valid_in,
    input  wire logic [WIDTH-1:0]           in_data_in,
    output logic                            in_ready_out,
    // drain side
    output logic                            out_valid_out,
    output logic      [WIDTH-1:0]           out_data_out,
    input  wire logic                       out_ready_in,
    // fill level
    output logic      [$clog2(DEPTH):0]     count_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire do_push = in_valid_in && in_ready_out;
    wire do_pop  = out_valid_out && out_ready_in;

    assign in_ready_out  = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out  = mem[rd_ptr];
    assign count_out     = count;

    always_ff @(posedge mclk_in) begin
        if (do_push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= do_push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= do_pop ? rd_ptr + 1'b1 : rd_ptr;
            count  <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule
`default_nettype wire

// >>> ubfw_core.sv
// Purpose: serial channel core: baud divider, gap, queues, status, wake
// Assumes: APB slave, zero wait states, inputs synchronous to mclk_in
// Notes:   fixed 8 data bits, optional even parity, one stop bit
//
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ubfw_cfg.svh"

module ubfw_core (
    // clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // serial lines
    output logic             txd_out,
    input  wire logic        rxd_in,
    input  wire logic        clear_to_send_n_in,
    // system
    input  wire logic        power_down_in,
    output logic             wake_out,
    output logic      [1:0]  func_mode_out
);
    // ************************************************************
    // baud period
    // ************************************************************
    function automatic logic [23:0] baud_period(input logic [1:0] md,
            input logic [15:0] div, input logic [3:0] pre);
        logic [23:0] b2;
        logic [23:0] p1;
        b2 = 24'(div) + `UBFW_BAUD_OFS;
        p1 = 24'(pre) + 24'h1;
        case (md)
            `UBFW_MODE_1: baud_period = 24'(p1 * b2);
            `UBFW_MODE_2: baud_period = b2;
            default:      baud_period = 24'(`UBFW_MODE0_MUL * b2);
        endcase
    endfunction

    logic [31:0] baud_divisor_reg;
    logic [31:0] timeout_delay_reg;
    logic [1:0]  function_select_reg;
    logic [1:0]  ctrl_reg;
    logic        tx_over;
    logic        rx_over;
    logic        wake_flag;
    logic [23:0] baud_cnt;
    logic [31:0] rd_q;
    logic        cts_q;
    wire         cts_edge;
    wire         wake_hit;

    ubfw_pkg::ubfw_tx_e tx_st;
    ubfw_pkg::ubfw_rx_e rx_st;
    logic [7:0]  tx_sh;
    logic        tx_par;
    logic [2:0]  tx_bit;
    logic [7:0]  tx_gap;
    logic [23:0] rx_cnt;
    logic [7:0]  rx_sh;
    logic [2:0]  rx_bit;
    logic        rx_par;
    logic        rx_perr;
    logic        rx_pbit;

    // ************************************************************
    // bus decode
    // ************************************************************
    wire        acc      = psel_in && penable_in;
    wire        setup    = psel_in && !penable_in;
    wire        wr       = acc && pwrite_in;
    wire        rd       = acc && !pwrite_in;
    wire        sel_data = (paddr_in == `UBFW_OFF_DATA);
    wire        sel_baud = (paddr_in == `UBFW_OFF_BAUD);
    wire        sel_tor  = (paddr_in == `UBFW_OFF_TOR);
    wire        sel_isr  = (paddr_in == `UBFW_OFF_ISR);
    wire        sel_lsr  = (paddr_in == `UBFW_OFF_LSR);
    wire        sel_fn   = (paddr_in == `UBFW_OFF_FUNSEL);
    wire        sel_ctrl = (paddr_in == `UBFW_OFF_CTRL);
    wire        mapped   = sel_data | sel_baud | sel_tor | sel_isr |
                           sel_lsr | sel_fn | sel_ctrl;
    wire        baud_wr  = wr && sel_baud;

    // ************************************************************
    // queues
    // ************************************************************
    wire        tx_in_ready;
    wire        tx_valid;
    wire [7:0]  tx_head;
    wire        tx_pop;
    wire [4:0]  tx_count;
    wire        rx_in_ready;
    wire        rx_valid;
    wire [10:0] rx_head;
    wire        rx_push;
    wire [10:0] rx_word;
    wire [4:0]  rx_count;
    wire        tx_push  = wr && sel_data;
    wire        rx_pop   = rd && sel_data && rx_valid;
    wire        tx_ovr_ev = tx_push && !tx_in_ready;
    wire        rx_ovr_ev = rx_push && !rx_in_ready;

    // transmit queue, a write into a full queue is dropped
    // queue path does not depend on function mode
    ubfw_fifo #(.WIDTH(8), .DEPTH(`UBFW_FIFO_DEPTH)) u_tx_fifo (
        .mclk_in       (mclk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (tx_push),
        .in_data_in    (pwdata_in[7:0]),
        .in_ready_out  (tx_in_ready),
        .out_valid_out (tx_valid),
        .out_data_out  (tx_head),
        .out_ready_in  (tx_pop),
        .count_out     (tx_count)
    );

    // break, frame and parity bits ride with the byte
    ubfw_fifo #(.WIDTH(11), .DEPTH(`UBFW_FIFO_DEPTH)) u_rx_fifo (
        .mclk_in       (mclk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (rx_push),
        .in_data_in    (rx_word),
        .in_ready_out  (rx_in_ready),
        .out_valid_out (rx_valid),
        .out_data_out  (rx_head),
        .out_ready_in  (rx_pop),
        .count_out     (rx_count)
    );

    // ************************************************************
    // baud generator
    // ************************************************************
    // divider mode from the mode field
    wire [23:0] period = baud_period(baud_divisor_reg[`UBFW_BAUD_MODE],
                                     baud_divisor_reg[`UBFW_BAUD_DIV],
                                     baud_divisor_reg[`UBFW_BAUD_PRE]);
    wire [23:0] last   = period - 24'h1;
    wire        tick   = (baud_cnt == last);
    // report settings outside the prescale and divisor limits
    wire        cfg_err =
        ((baud_divisor_reg[`UBFW_BAUD_MODE] == `UBFW_MODE_1) &&
         (baud_divisor_reg[`UBFW_BAUD_PRE] < `UBFW_PRE_MIN)) ||
        ((baud_divisor_reg[`UBFW_BAUD_MODE] == `UBFW_MODE_2) &&
         (baud_divisor_reg[`UBFW_BAUD_DIV] < `UBFW_M2_DIV_MIN));

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            baud_cnt <= 24'h0;
        end else if (baud_wr || tick) begin
            baud_cnt <= 24'h0;
        end else begin
            baud_cnt <= baud_cnt + 24'h1;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    wire [31:0] isr_val = {21'h0, wake_flag, rx_over, tx_over, 2'h0,
                           tx_over | rx_over, 5'h0};
    wire        tx_busy = (tx_st != ubfw_pkg::TX_IDLE);
    wire        rx_busy = (rx_st != ubfw_pkg::RX_IDLE);
    // live transfer state and head-byte errors
    wire [31:0] lsr_val = {22'h0, cfg_err, rx_busy, tx_busy,
                           rx_head[10:8], !rx_in_ready, !rx_valid,
                           !tx_in_ready, !tx_valid};
    wire [31:0] rd_mux =
        sel_data ? {21'h0, rx_head} :
        sel_baud ? baud_divisor_reg :
        sel_tor  ? timeout_delay_reg :
        sel_isr  ? isr_val :
        sel_lsr  ? lsr_val :
        sel_fn   ? {30'h0, function_select_reg} :
        sel_ctrl ? {30'h0, ctrl_reg} : 32'h0;

    assign pready_out    = 1'b1;
    assign pslverr_out   = acc && !mapped;
    assign prdata_out    = rd_q;
    // function mode from its select register
    assign func_mode_out = function_select_reg;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_q <= 32'h0;
        end else if (setup) begin
            rd_q <= rd_mux;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            baud_divisor_reg    <= `UBFW_RST_BAUD;
            timeout_delay_reg   <= `UBFW_RST_TOR;
            function_select_reg <= ubfw_pkg::FN_UART;
            ctrl_reg            <= 2'h0;
        end else if (wr) begin
            if (sel_baud) baud_divisor_reg <= pwdata_in;
            if (sel_tor)  timeout_delay_reg <= pwdata_in;
            if (sel_fn)   function_select_reg <= pwdata_in[1:0];
            if (sel_ctrl) ctrl_reg <= pwdata_in[1:0];
        end
    end

    // sticky flags: a new event wins over a write-one clear
    wire isr_w1c = wr && sel_isr;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_over   <= 1'b0;
            rx_over   <= 1'b0;
            wake_flag <= 1'b0;
        end else begin
            tx_over   <= tx_ovr_ev |
                         (tx_over & !(isr_w1c & pwdata_in[`UBFW_ISR_TXOVER]));
            rx_over   <= rx_ovr_ev |
                         (rx_over & !(isr_w1c & pwdata_in[`UBFW_ISR_RXOVER]));
            wake_flag <= wake_hit |
                         (wake_flag & !(isr_w1c & pwdata_in[`UBFW_ISR_WAKE]));
        end
    end

    // ************************************************************
    // wake-up
    // ************************************************************
    // either edge of clear-to-send
    assign cts_edge = cts_q ^ clear_to_send_n_in;
    // only while powered down and enabled
    assign wake_hit = power_down_in && ctrl_reg[`UBFW_CTRL_WAKEEN] && cts_edge;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cts_q    <= 1'b1;
            wake_out <= 1'b0;
        end else begin
            cts_q    <= clear_to_send_n_in;
            wake_out <= wake_hit;
        end
    end

    // ************************************************************
    // transmitter
    // ************************************************************
    wire       par_en  = ctrl_reg[`UBFW_CTRL_PAREN];
    wire [7:0] gap_len = timeout_delay_reg[`UBFW_TOR_GAP];
    wire       tx_end  = tick && ((tx_st == ubfw_pkg::TX_IDLE) ||
                        (tx_st == ubfw_pkg::TX_STOP && gap_len == 8'h0) ||
                        (tx_st == ubfw_pkg::TX_GAP && tx_gap == gap_len));
    assign tx_pop = tx_end && tx_valid;

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tx_st   <= ubfw_pkg::TX_IDLE;
            txd_out <= 1'b1;
            tx_sh   <= 8'h0;
            tx_par  <= 1'b0;
            tx_bit  <= 3'h0;
            tx_gap  <= 8'h0;
        end else if (tx_pop) begin
            tx_st   <= ubfw_pkg::TX_START;
            txd_out <= 1'b0;
            tx_sh   <= tx_head;
            tx_par  <= ^tx_head;
        end else if (tx_end) begin
            tx_st   <= ubfw_pkg::TX_IDLE;
        end else if (tick) begin
            case (tx_st)
                ubfw_pkg::TX_START: begin
                    tx_st   <= ubfw_pkg::TX_DATA;
                    txd_out <= tx_sh[0];
                    tx_bit  <= 3'h0;
                end
                ubfw_pkg::TX_DATA: begin
                    tx_sh  <= {1'b0, tx_sh[7:1]};
                    tx_bit <= tx_bit + 3'h1;
                    if (tx_bit == 3'h7) begin
                        tx_st   <= par_en ? ubfw_pkg::TX_PAR
                                          : ubfw_pkg::TX_STOP;
                        txd_out <= par_en ? tx_par : 1'b1;
                    end else begin
                        txd_out <= tx_sh[1];
                    end
                end
                ubfw_pkg::TX_PAR: begin
                    tx_st   <= ubfw_pkg::TX_STOP;
                    txd_out <= 1'b1;
                end
                // idle gap after the stop bit
                ubfw_pkg::TX_STOP: begin
                    tx_st  <= ubfw_pkg::TX_GAP;
                    tx_gap <= 8'h1;
                end
                ubfw_pkg::TX_GAP: begin
                    tx_gap <= tx_gap + 8'h1;
                end
                default: begin
                    tx_st   <= ubfw_pkg::TX_IDLE;
                    txd_out <= 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // receiver
    // ************************************************************
    wire rx_smp   = rx_busy && (rx_cnt == 24'h0);
    wire rx_frame = !rxd_in;
    wire rx_brk   = (rx_sh == 8'h0) && !rx_pbit && !rxd_in;
    assign rx_push = rx_smp && (rx_st == ubfw_pkg::RX_STOP);
    assign rx_word = {rx_brk, rx_frame, rx_perr, rx_sh};

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_st   <= ubfw_pkg::RX_IDLE;
            rx_cnt  <= 24'h0;
            rx_sh   <= 8'h0;
            rx_bit  <= 3'h0;
            rx_par  <= 1'b0;
            rx_perr <= 1'b0;
            rx_pbit <= 1'b0;
        end else if (!rx_busy) begin
            if (!rxd_in) begin
                rx_st   <= ubfw_pkg::RX_START;
                rx_cnt  <= {1'b0, period[23:1]};
                rx_perr <= 1'b0;
                rx_pbit <= 1'b0;
            end
        end else if (!rx_smp) begin
            rx_cnt <= rx_cnt - 24'h1;
        end else begin
            rx_cnt <= last;
            case (rx_st)
                ubfw_pkg::RX_START: begin
                    rx_st  <= rxd_in ? ubfw_pkg::RX_IDLE : ubfw_pkg::RX_DATA;
                    rx_bit <= 3'h0;
                    rx_par <= 1'b0;
                end
                ubfw_pkg::RX_DATA: begin
                    rx_sh  <= {rxd_in, rx_sh[7:1]};
                    rx_par <= rx_par ^ rxd_in;
                    rx_bit <= rx_bit + 3'h1;
                    if (rx_bit == 3'h7) begin
                        rx_st <= par_en ? ubfw_pkg::RX_PAR
                                        : ubfw_pkg::RX_STOP;
                    end
                end
                ubfw_pkg::RX_PAR: begin
                    rx_st   <= ubfw_pkg::RX_STOP;
                    rx_perr <= rx_par ^ rxd_in;
                    rx_pbit <= rxd_in;
                end
                default: begin
                    rx_st <= ubfw_pkg::RX_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    chk_buf_err_set: assert property (
        (tx_ovr_ev || rx_ovr_ev) |=> isr_val[`UBFW_ISR_BUFERR])
        else $error("buffer error flag not set after overrun");
    chk_tick_single: assert property (
        tick |=> !tick)
        else $error("baud tick longer than one cycle");
    chk_baud_restart: assert property (
        baud_wr |=> (baud_cnt == 24'h0) ##1 (baud_cnt == 24'h1) || tick)
        else $error("baud count did not restart on divisor write");
    chk_wake_edge: assert property (
        (power_down_in && ctrl_reg[`UBFW_CTRL_WAKEEN] &&
         $changed(clear_to_send_n_in)) |=> wake_out)
        else $error("clear-to-send edge did not wake");
    chk_wake_quiet: assert property (
        !power_down_in |=> !wake_out)
        else $error("wake pulse outside power-down");
    chk_mode2_period: assert property (
        (baud_divisor_reg[`UBFW_BAUD_MODE] == `UBFW_MODE_2) |->
        (period == 24'(baud_divisor_reg[`UBFW_BAUD_DIV]) + 24'h2))
        else $error("mode 2 period wrong");
    chk_gap_entry: assert property (
        (tick && tx_st == ubfw_pkg::TX_STOP && gap_len != 8'h0 &&
         !baud_wr) |=> (tx_st == ubfw_pkg::TX_GAP) && txd_out)
        else $error("no idle gap after stop bit");
    chk_rx_frame_err: assert property (
        (rx_push && !rxd_in && rx_in_ready) |=> rx_count != 5'h0)
        else $error("framed byte not stored");
    chk_fifo_bound: assert property (
        (tx_count <= 5'h10) && (rx_count <= 5'h10))
        else $error("queue beyond sixteen entries");
    chk_lsr_read: assert property (
        (setup && sel_lsr) |=> (rd_q[1:0] == {$past(!tx_in_ready),
                                              $past(!tx_valid)}))
        else $error("status read does not show queue state");

    cov_tx_frame: cover property (tx_pop ##[1:300] tx_st == ubfw_pkg::TX_GAP);
    cov_rx_byte:  cover property (rx_push && rx_in_ready);
    cov_overrun:  cover property (tx_ovr_ev);
    cov_wake:     cover property (wake_out);
endmodule
`default_nettype wire

// >>> ubfw_peer.sv
// Purpose: serial peer model on the far side
// Assumes: bit period given in mclk_in cycles
// Notes:   stop level chosen per frame
`timescale 1ns/1ps
`default_nettype none
module ubfw_peer (
    // clock
    input  wire logic mclk_in,
    // lines
    output logic      rxd_out,
    output logic      cts_n_out
);
    initial begin
        rxd_out = 1'b1;
        cts_n_out = 1'b1;
    end
    // start, eight bits lsb first, stop
    task automatic send(input logic [7:0] b, input logic stp, input int per);
        logic [9:0] f;
        f = {stp, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge mclk_in);
            rxd_out <= f[i];
            repeat (per - 1) @(posedge mclk_in);
        end
        @(posedge mclk_in);
        rxd_out <= 1'b1;
        repeat (2 * per) @(posedge mclk_in);
    endtask
    task automatic toggle_cts();
        @(posedge mclk_in);
        cts_n_out <= ~cts_n_out;
    endtask
endmodule
`default_nettype wire

// >>> testbench.sv
// Purpose: self-checking bench of ubfw_core
// Assumes: zero-wait APB, peer on serial lines
// Notes:   fixed stimulus only
`timescale 1ns/1ps
`default_nettype none
`include "ubfw_cfg.svh"
module testbench;
    logic        mclk, rst_n, psel, pen, pwr, pd, prdy, perr;
    logic        txd, rxd, cts_n, wake, e;
    logic [7:0]  paddr;
    logic [31:0] pwd, prd, r;
    logic [1:0]  fm;
    int          mismatches, n_checks, n;
    ubfw_core dut (.mclk_in(mclk), .rst_n_in(rst_n), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
        .pslverr_out(perr), .txd_out(txd), .rxd_in(rxd),
        .clear_to_send_n_in(cts_n), .power_down_in(pd),
        .wake_out(wake), .func_mode_out(fm));
    ubfw_peer peer (.mclk_in(mclk), .rxd_out(rxd), .cts_n_out(cts_n));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // ****
    // tasks
    // ****
    task automatic chk(input string s, input logic [31:0] v, x);
        n_checks++;
        if (v !== x) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", s, x, v);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge mclk);
        pen <= 1'b1;
        do begin
            @(posedge mclk);
        end while (prdy !== 1'b1);
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic step();
        n++;
        @(posedge mclk);
    endtask
    task automatic t_reset();
        chk("txd", txd, 1'b1);
        chk("fmode", fm, 2'h0);
        apb(1'b0, `UBFW_OFF_BAUD, 32'h0);
        chk("baud", r, `UBFW_RST_BAUD);
        apb(1'b0, 8'h40, 32'h0);
        chk("slverr", e, 1'b1);
        $display("end t_reset");
    endtask
    task automatic t_baud(input logic [31:0] bv, input int per,
                          input logic [1:0] fn);
        apb(1'b1, `UBFW_OFF_FUNSEL, {30'h0, fn});
        apb(1'b1, `UBFW_OFF_BAUD, bv);
        apb(1'b1, `UBFW_OFF_DATA, 32'h01);
        n = 0;
        while (txd !== 1'b0 && n < 9000) step();
        n = 0;
        while (txd === 1'b0 && n < 9000) step();
        chk("period", n, per);
        chk("fmode", fm, fn);
        repeat (10 * per) @(posedge mclk);
        $display("end t_baud");
    endtask
    task automatic t_gap();
        apb(1'b1, `UBFW_OFF_TOR, 32'h300);
        apb(1'b1, `UBFW_OFF_DATA, 32'hFF);
        apb(1'b1, `UBFW_OFF_DATA, 32'hFF);
        n = 0;
        while (txd !== 1'b0 && n < 900) step();
        n = 0;
        do step(); while (txd === 1'b0 && n < 900);
        while (txd === 1'b1 && n < 900) step();
        chk("gap", n, 13 * 11);
        apb(1'b1, `UBFW_OFF_TOR, 32'h0);
        apb(1'b0, `UBFW_OFF_LSR, 32'h0);
        chk("lsr_busy", r, 32'h085);
        repeat (150) @(posedge mclk);
        $display("end t_gap");
    endtask
    task automatic t_rx();
        peer.send(8'hA5, 1'b1, 11);
        peer.send(8'h3C, 1'b0, 11);
        peer.send(8'h00, 1'b0, 11);
        apb(1'b0, `UBFW_OFF_LSR, 32'h0);
        chk("lsr_idle", r, 32'h001);
        apb(1'b0, `UBFW_OFF_DATA, 32'h0);
        chk("rx_ok", r, 32'h0A5);
        apb(1'b0, `UBFW_OFF_DATA, 32'h0);
        chk("rx_frame", r, 32'h23C);
        apb(1'b0, `UBFW_OFF_LSR, 32'h0);
        chk("lsr_errs", r, 32'h061);
        apb(1'b0, `UBFW_OFF_DATA, 32'h0);
        chk("rx_break", r, 32'h600);
        $display("end t_rx");
    endtask
    task automatic t_over();
        apb(1'b1, `UBFW_OFF_BAUD, 32'h64);
        for (int i = 0; i < 18; i++) apb(1'b1, `UBFW_OFF_DATA, i);
        apb(1'b0, `UBFW_OFF_ISR, 32'h0);
        chk("over", r & 32'h120, 32'h120);
        apb(1'b1, `UBFW_OFF_ISR, 32'h100);
        apb(1'b0, `UBFW_OFF_ISR, 32'h0);
        chk("buf_err", r[5], 1'b0);
        apb(1'b1, `UBFW_OFF_BAUD, 32'h3000_0009);
        repeat (2200) @(posedge mclk);
        $display("end t_over");
    endtask
    task automatic t_wake(input logic p, input int x);
        @(posedge mclk);
        pd <= p;
        peer.toggle_cts();
        n = 0;
        repeat (6) begin
            @(posedge mclk);
            if (wake === 1'b1) n++;
        end
        chk("wake", n, x);
        $display("end t_wake");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ****
    // sequence
    // ****
    initial begin
        {rst_n, psel, pen, pwr, pd, paddr, pwd} = '0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_baud(32'h0000_0001, 48, 2'h2);
        t_baud(32'h2800_0000, 18, 2'h0);
        t_baud(32'h0000_0000, 32, 2'h1);
        t_baud(32'h3000_0009, 11, 2'h3);
        t_gap();
        t_rx();
        t_over();
        apb(1'b1, `UBFW_OFF_CTRL, 32'h2);
        t_wake(1'b0, 0);
        t_wake(1'b1, 1);
        t_wake(1'b1, 1);
        apb(1'b0, `UBFW_OFF_ISR, 32'h0);
        chk("wake_flag", r[10], 1'b1);
        wrap_up();
    end
    initial begin
        repeat (60000) @(posedge mclk);
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire
